// file: src/mrp_message_ram.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// How it works
// - Storage words have no host window; host traffic uses the staging buffers.
// - Storage holds 2048 words of 32 data bits plus one parity bit.
// - Data partition starts at (last configured buffer plus one) times four.
// - Up to 128 buffers, four header words each, buffer 0 lowest.
// - Data section spans 0 to 254 bytes from its pointer and length.
// - A valid received frame updates received length, cycle count and indicators.
// - Header word one holds filters, direction, preamble, shot mode, irq enable.
// - Header word two holds CRC and both lengths in 2-byte units.
// - The status word is written at the end of the buffer's slot.
// - Status fields are kept or cleared by buffer direction.
// - An odd length leaves the upper 16 bits of the last word unused.
// - Even parity is made on every write and checked on every read.
// - Any parity error sets its path flag and the error register flag.
// - Input copy error flags buffer number and blocks its transmit request.
// - Header scan error flags buffer number and ignores that buffer.
// - Storage to transient error flags buffer and abandons the frame.
// - Transient to channel error sets transient flag and halts the frame.
// - Transient to storage error sets transient flag and buffer number.
// - Host staging reads and storage to output copies set their flags.
// - A management frame with parity error or no buffer keeps the vector.
module mrp_message_ram #(
   parameter int DEPTH = mrp_pkg::MEM_WORDS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Message handler storage port
   input wire mrp_pkg::mrp_mh_req_type mh_req,
   output logic mh_ready,
   output logic [31:0] mh_rdata,
   output logic mh_rvalid,
   // Frame and slot events
   input wire mrp_pkg::mrp_rx_req_type rx_req,
   input wire mrp_pkg::mrp_slot_req_type slot_req,
   // Words read from staging and transient RAMs
   input wire mrp_pkg::mrp_ext_chk_type ext_chk,
   // Parity error consequences
   output logic txreq_block,
   output logic [6:0] ext_evt_buf,
   output logic buf_ignore,
   output logic tx_abandon,
   output logic [6:0] mem_evt_buf,
   output logic [1:0] tx_halt,
   output logic nmv_update,
   // Status
   output logic [10:0] data_start,
   output logic parity_error_flag
);
   mrp_pkg::mrp_state_type s;
   mrp_pkg::mrp_state_type n;
   logic [mrp_pkg::DW:0] mem [DEPTH];
   logic m_we;
   logic m_re;
   logic [mrp_pkg::AW-1:0] m_addr;
   logic [mrp_pkg::DW-1:0] m_wd;
   logic m_par;
   logic q_err;
   logic x_err;
   logic hit;
   logic [7:0] d_words;
   logic [10:0] d_addr;
   logic d_ok;
   logic d_half;
   mrp_pkg::mrp_hdr_len_type len_w;
   mrp_pkg::mrp_hdr_ptr_type ptr_w;
   mrp_pkg::mrp_hdr_cfg_type cfg_w;
   mrp_pkg::mrp_status_word_type st_w;

   mrp_par_gen #(
      .W(mrp_pkg::DW)
   ) u_gen (
      .data(m_wd),
      .par(m_par)
   );

   mrp_par_chk #(
      .W(mrp_pkg::DW)
   ) u_chk_mem (
      .word(s.q),
      .err(q_err)
   );

   mrp_par_chk #(
      .W(mrp_pkg::DW)
   ) u_chk_ext (
      .word(ext_chk.word),
      .err(x_err)
   );

   // Extent of the addressed data section in words
   assign d_words = 8'((9'(mh_req.cfg_payload_length) + 9'h001) >> 1);
   assign d_ok = mh_req.idx < 11'(d_words);
   assign d_half = mh_req.cfg_payload_length[0]
      && (mh_req.idx == 11'(mh_req.cfg_payload_length >> 1));
   // The pointer is trusted; a stray one wraps inside the storage
   assign d_addr = mh_req.data_pointer + mh_req.idx;

   always_comb begin
      n = s;
      hit = 1'b0;
      n.txreq_block = 1'b0;
      n.ignore = 1'b0;
      n.abandon = 1'b0;
      n.halt = 2'h0;
      n.nmv = 1'b0;
      n.rd_pend = 1'b0;
      m_we = 1'b0;
      m_re = 1'b0;
      m_addr = 11'h000;
      m_wd = 32'h0000_0000;
      len_w = s.q[31:0];
      ptr_w = s.q[31:0];
      cfg_w = s.q[31:0];
      st_w = s.sl_st;

      // Software clears are applied first so that a same-cycle set wins
      if (reg_wr) begin
         case (reg_addr)
            mrp_pkg::OFS_STORAGE_CFG: begin
               n.cfg_last = reg_wdata[7:0];
            end
            mrp_pkg::OFS_HANDLER_STATUS: begin
               n.hs = mrp_pkg::mrp_hs_type'(s.hs & ~(reg_wdata & mrp_pkg::HS_W1C_MASK));
            end
            mrp_pkg::OFS_ERROR_IRQ: begin
               n.par_err = s.par_err & ~reg_wdata[0];
            end
            default: begin
            end
         endcase
      end
      n.dstart = 11'((11'(n.cfg_last) + 11'h001) * mrp_pkg::DP_SCALE);

      if (reg_rd) begin
         case (reg_addr)
            mrp_pkg::OFS_STORAGE_CFG: begin
               n.rdata = {24'h000000, s.cfg_last};
            end
            mrp_pkg::OFS_HANDLER_STATUS: begin
               n.rdata = s.hs;
            end
            mrp_pkg::OFS_ERROR_IRQ: begin
               n.rdata = {31'h0000_0000, s.par_err};
            end
            mrp_pkg::OFS_DATA_START: begin
               n.rdata = {21'h00_0000, s.dstart};
            end
            default: begin
               // No address reaches a storage word from here
               n.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Message handler access, one word per cycle while ready
      if (s.ready && mh_req.valid) begin
         if (mh_req.data_acc) begin
            m_addr = d_addr;
         end else begin
            m_addr = {2'h0, mh_req.buf_num, mh_req.idx[1:0]};
         end
         if (!mh_req.data_acc || d_ok) begin
            m_we = mh_req.we;
            m_re = !mh_req.we;
            n.rd_pend = !mh_req.we;
            n.rd_path = mh_req.path;
            n.rd_buf = mh_req.buf_num;
         end
         m_wd = mh_req.wdata;
         if (mh_req.data_acc && d_half) begin
            m_wd[31:16] = 16'h0000;
         end
      end

      // Header updates own the port only while the handler is held off
      case (s.fsm)
         mrp_pkg::ST_IDLE: begin
            if (!s.ready && s.rx_pend) begin
               m_re = 1'b1;
               m_addr = {2'h0, s.rx_buf, mrp_pkg::HW_LEN};
               n.fsm = mrp_pkg::ST_RX_WR1;
            end else if (!s.ready && s.sl_pend) begin
               m_re = 1'b1;
               m_addr = {2'h0, s.sl_buf, mrp_pkg::HW_CFG};
               n.fsm = mrp_pkg::ST_SL_WR;
            end
         end
         mrp_pkg::ST_RX_WR1: begin
            if (q_err) begin
               hit = 1'b1;
               n.hs.storage_parity_flag = 1'b1;
               n.hs.faulty_buffer_valid = 1'b1;
               n.hs.faulty_buffer_number = s.rx_buf;
               n.rx_pend = 1'b0;
               n.fsm = mrp_pkg::ST_IDLE;
            end else begin
               // Configured length and CRC are kept as they were
               len_w.received_payload_length = s.rx_info.received_payload_length;
               m_we = 1'b1;
               m_addr = {2'h0, s.rx_buf, mrp_pkg::HW_LEN};
               m_wd = len_w;
               n.fsm = mrp_pkg::ST_RX_RD2;
            end
         end
         mrp_pkg::ST_RX_RD2: begin
            m_re = 1'b1;
            m_addr = {2'h0, s.rx_buf, mrp_pkg::HW_PTR};
            n.fsm = mrp_pkg::ST_RX_WR2;
         end
         mrp_pkg::ST_RX_WR2: begin
            n.rx_pend = 1'b0;
            n.fsm = mrp_pkg::ST_IDLE;
            if (q_err) begin
               hit = 1'b1;
               n.hs.storage_parity_flag = 1'b1;
               n.hs.faulty_buffer_valid = 1'b1;
               n.hs.faulty_buffer_number = s.rx_buf;
            end else begin
               // The data pointer in the same word is left untouched
               ptr_w.receive_cycle_count = s.rx_info.receive_cycle_count;
               ptr_w.flags = s.rx_info.flags;
               m_we = 1'b1;
               m_addr = {2'h0, s.rx_buf, mrp_pkg::HW_PTR};
               m_wd = ptr_w;
            end
         end
         mrp_pkg::ST_SL_WR: begin
            n.sl_pend = 1'b0;
            n.fsm = mrp_pkg::ST_IDLE;
            if (q_err) begin
               // A buffer whose header cannot be trusted is skipped
               hit = 1'b1;
               n.hs.storage_parity_flag = 1'b1;
               n.hs.faulty_buffer_valid = 1'b1;
               n.hs.faulty_buffer_number = s.sl_buf;
               n.ignore = 1'b1;
               n.mem_buf = s.sl_buf;
            end else begin
               // Direction comes from the stored first header word
               if (cfg_w.tx_dir) begin
                  st_w = mrp_pkg::mrp_status_word_type'(s.sl_st & mrp_pkg::TX_KEEP);
               end else begin
                  st_w = mrp_pkg::mrp_status_word_type'(s.sl_st & mrp_pkg::RX_KEEP);
               end
               m_we = 1'b1;
               m_addr = {2'h0, s.sl_buf, mrp_pkg::HW_STAT};
               m_wd = st_w;
            end
         end
         default: begin
            n.fsm = mrp_pkg::ST_IDLE;
         end
      endcase

      // Check of a storage word returned to the handler
      if (s.rd_pend && q_err) begin
         hit = 1'b1;
         n.hs.storage_parity_flag = 1'b1;
         n.hs.faulty_buffer_valid = 1'b1;
         n.hs.faulty_buffer_number = s.rd_buf;
         case (s.rd_path)
            mrp_pkg::P_HDR_SCAN: begin
               n.ignore = 1'b1;
               n.mem_buf = s.rd_buf;
            end
            mrp_pkg::P_MEM_TBF: begin
               n.abandon = 1'b1;
               n.mem_buf = s.rd_buf;
            end
            default: begin
               // Storage to output staging copy
            end
         endcase
      end

      // Check of a word read from a staging or transient RAM
      if (ext_chk.valid && x_err) begin
         hit = 1'b1;
         case (ext_chk.path)
            mrp_pkg::P_IBF_MEM: begin
               n.hs.input_buffer_parity_flag = 1'b1;
               n.hs.faulty_buffer_valid = 1'b1;
               n.hs.faulty_buffer_number = ext_chk.buf_num;
               n.txreq_block = 1'b1;
               n.ext_buf = ext_chk.buf_num;
            end
            mrp_pkg::P_IBF_HOST: begin
               n.hs.input_buffer_parity_flag = 1'b1;
            end
            mrp_pkg::P_OBF_HOST: begin
               n.hs.output_buffer_parity_flag = 1'b1;
            end
            mrp_pkg::P_TBF_CPC: begin
               if (ext_chk.chan) begin
                  n.hs.transient_two_parity_flag = 1'b1;
               end else begin
                  n.hs.transient_one_parity_flag = 1'b1;
               end
               n.halt[ext_chk.chan] = 1'b1;
            end
            mrp_pkg::P_TBF_MEM: begin
               if (ext_chk.chan) begin
                  n.hs.transient_two_parity_flag = 1'b1;
               end else begin
                  n.hs.transient_one_parity_flag = 1'b1;
               end
               n.hs.faulty_buffer_valid = 1'b1;
               n.hs.faulty_buffer_number = ext_chk.buf_num;
            end
            default: begin
               // Storage-side paths are checked on the storage read above
            end
         endcase
      end

      // The vector moves only for a clean management frame that has a buffer
      if (ext_chk.valid && ext_chk.mgmt && ext_chk.mgmt_match && !x_err) begin
         n.nmv = 1'b1;
      end

      if (hit) begin
         n.par_err = 1'b1;
      end

      // Events are latched after the state machine so one arriving in the cycle it clears its flag is kept; a newer one replaces a pending one
      if (rx_req.valid) begin
         n.rx_pend = 1'b1;
         n.rx_buf = rx_req.buf_num;
         n.rx_info = rx_req.info;
      end
      if (slot_req.valid) begin
         n.sl_pend = 1'b1;
         n.sl_buf = slot_req.buf_num;
         n.sl_st = slot_req.status;
      end
      n.ready = (n.fsm == mrp_pkg::ST_IDLE) && !n.rx_pend && !n.sl_pend;

      if (m_re) begin
         n.q = mem[m_addr];
      end
   end

   // Storage array: parity travels with every word
   always_ff @(posedge mclk) begin
      if (m_we) begin
         mem[m_addr] <= {m_par, m_wd};
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.fsm <= mrp_pkg::ST_IDLE;
         s.cfg_last <= mrp_pkg::CFG_LAST_RESET;
         s.dstart <= mrp_pkg::DSTART_RESET;
      end else begin
         s <= n;
      end
   end

   assign reg_rdata = s.rdata;
   assign mh_ready = s.ready;
   assign mh_rdata = s.q[31:0];
   assign mh_rvalid = s.rd_pend;
   assign txreq_block = s.txreq_block;
   assign ext_evt_buf = s.ext_buf;
   assign buf_ignore = s.ignore;
   assign tx_abandon = s.abandon;
   assign mem_evt_buf = s.mem_buf;
   assign tx_halt = s.halt;
   assign nmv_update = s.nmv;
   assign data_start = s.dstart;
   assign parity_error_flag = s.par_err;
endmodule : mrp_message_ram

// file: src/mrp_par_chk.sv
`timescale 1ns/100ps
module mrp_par_chk #(
   parameter int W = 32
) (
   // Stored parity bit on top of the data
   input wire logic [W:0] word,
   // High when the ones count of data and parity is odd
   output logic err
);
   assign err = ^word;
endmodule : mrp_par_chk

// file: src/mrp_par_gen.sv
`timescale 1ns/100ps
module mrp_par_gen #(
   parameter int W = 32
) (
   // Word being written
   input wire logic [W-1:0] data,
   // Even parity bit
   output logic par
);
   assign par = ^data;
endmodule : mrp_par_gen

// file: src/mrp_pkg.sv
package mrp_pkg;
   // Storage geometry
   localparam int MEM_WORDS = 2048;
   localparam int DW = 32;
   localparam int AW = 11;
   localparam logic [10:0] DP_SCALE = 11'h004;
   // Register map on the plain port, byte addresses
   localparam logic [7:0] OFS_STORAGE_CFG = 8'h00;
   localparam logic [7:0] OFS_HANDLER_STATUS = 8'h04;
   localparam logic [7:0] OFS_ERROR_IRQ = 8'h08;
   localparam logic [7:0] OFS_DATA_START = 8'h0c;
   // Values after reset
   localparam logic [7:0] CFG_LAST_RESET = 8'h00;
   localparam logic [10:0] DSTART_RESET = 11'h004;
   // Handler status bits that a written one clears
   localparam logic [31:0] HS_W1C_MASK = 32'h0000_003f;
   // Header word index within a buffer's four-word header
   localparam logic [1:0] HW_CFG = 2'h0;
   localparam logic [1:0] HW_LEN = 2'h1;
   localparam logic [1:0] HW_PTR = 2'h2;
   localparam logic [1:0] HW_STAT = 2'h3;
   // Status bits kept for transmit and for receive buffers
   localparam logic [31:0] TX_KEEP = 32'h0000_03ff;
   localparam logic [31:0] RX_KEEP = 32'h07ff_fcff;

   typedef enum logic [2:0] {
      P_IBF_MEM = 3'h0,
      P_IBF_HOST = 3'h1,
      P_OBF_HOST = 3'h2,
      P_HDR_SCAN = 3'h3,
      P_MEM_TBF = 3'h4,
      P_MEM_OBF = 3'h5,
      P_TBF_MEM = 3'h6,
      P_TBF_CPC = 3'h7
   } mrp_path_type;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX_WR1 = 5'h02,
      ST_RX_RD2 = 5'h04,
      ST_RX_WR2 = 5'h08,
      ST_SL_WR = 5'h10
   } mrp_fsm_type;

   typedef struct packed {
      logic [1:0] unused_hi;
      logic buffer_irq_enable;
      logic tx_shot_mode;
      logic preamble_indicator_tx;
      logic tx_dir;
      logic channel_b_filter;
      logic channel_a_filter;
      logic unused_mid;
      logic [6:0] cycle_code;
      logic [4:0] unused_lo;
      logic [10:0] frame_id;
   } mrp_hdr_cfg_type;

   typedef struct packed {
      logic unused_hi;
      logic [6:0] received_payload_length;
      logic unused_mid;
      logic [6:0] cfg_payload_length;
      logic [4:0] unused_lo;
      logic [10:0] header_crc;
   } mrp_hdr_len_type;

   typedef struct packed {
      logic reserved_bit;
      logic preamble_indicator;
      logic null_frame_indicator;
      logic sync_frame_indicator;
      logic startup_frame_indicator;
      logic receive_channel_indicator;
   } mrp_rx_flags_type;

   typedef struct packed {
      logic [1:0] unused_hi;
      mrp_rx_flags_type flags;
      logic [1:0] unused_mid;
      logic [5:0] receive_cycle_count;
      logic [4:0] unused_lo;
      logic [10:0] data_pointer;
   } mrp_hdr_ptr_type;

   typedef struct packed {
      mrp_rx_flags_type flags;
      logic [5:0] receive_cycle_count;
      logic [6:0] received_payload_length;
   } mrp_rx_info_type;

   typedef struct packed {
      logic [4:0] unused;
      logic [5:0] status_cycle;
      mrp_rx_flags_type copies;
      logic frame_tx_b;
      logic frame_tx_a;
      logic message_lost;
      logic empty_slot_b;
      logic empty_slot_a;
      logic tx_collision_b;
      logic tx_collision_a;
      logic slot_boundary_error_b;
      logic slot_boundary_error_a;
      logic content_error_b;
      logic content_error_a;
      logic syntax_error_b;
      logic syntax_error_a;
      logic valid_frame_b;
      logic valid_frame_a;
   } mrp_status_word_type;

   typedef struct packed {
      logic [16:0] unused_hi;
      logic [6:0] faulty_buffer_number;
      logic [1:0] unused_lo;
      logic faulty_buffer_valid;
      logic transient_two_parity_flag;
      logic transient_one_parity_flag;
      logic storage_parity_flag;
      logic output_buffer_parity_flag;
      logic input_buffer_parity_flag;
   } mrp_hs_type;

   typedef struct packed {
      logic valid;
      logic we;
      logic data_acc;
      mrp_path_type path;
      logic [6:0] buf_num;
      logic [10:0] idx;
      logic [10:0] data_pointer;
      logic [6:0] cfg_payload_length;
      logic [31:0] wdata;
   } mrp_mh_req_type;

   typedef struct packed {
      logic valid;
      logic [6:0] buf_num;
      mrp_rx_info_type info;
   } mrp_rx_req_type;

   typedef struct packed {
      logic valid;
      logic [6:0] buf_num;
      mrp_status_word_type status;
   } mrp_slot_req_type;

   typedef struct packed {
      logic valid;
      mrp_path_type path;
      logic chan;
      logic mgmt;
      logic mgmt_match;
      logic [6:0] buf_num;
      logic [32:0] word;
   } mrp_ext_chk_type;

   typedef struct packed {
      mrp_fsm_type fsm;
      logic [7:0] cfg_last;
      logic [10:0] dstart;
      mrp_hs_type hs;
      logic par_err;
      logic [31:0] rdata;
      logic [32:0] q;
      logic ready;
      logic rd_pend;
      mrp_path_type rd_path;
      logic [6:0] rd_buf;
      logic rx_pend;
      logic [6:0] rx_buf;
      mrp_rx_info_type rx_info;
      logic sl_pend;
      logic [6:0] sl_buf;
      mrp_status_word_type sl_st;
      logic txreq_block;
      logic [6:0] ext_buf;
      logic ignore;
      logic abandon;
      logic [6:0] mem_buf;
      logic [1:0] halt;
      logic nmv;
   } mrp_state_type;
endpackage : mrp_pkg

// file: verif/mrp_chk.sv
`timescale 1ns/100ps
module mrp_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   // Handler and events
   input wire mrp_pkg::mrp_mh_req_type mh_req,
   input wire logic mh_ready,
   input wire logic mh_rvalid,
   input wire mrp_pkg::mrp_rx_req_type rx_req,
   input wire mrp_pkg::mrp_slot_req_type slot_req,
   input wire mrp_pkg::mrp_ext_chk_type ext_chk,
   // Outcomes
   input wire logic txreq_block,
   input wire logic [1:0] tx_halt,
   input wire logic nmv_update,
   input wire logic [10:0] data_start,
   input wire logic parity_error_flag
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   logic bad;
   assign bad = ext_chk.valid && (^ext_chk.word);
   sequence s_rx;
      !mh_ready [*4] ##1 mh_ready;
   endsequence
   sequence s_sl;
      !mh_ready [*2] ##1 mh_ready;
   endsequence
   chk_rx_update: assert property (rx_req.valid && !slot_req.valid && mh_ready |=> s_rx)
      else $error("rx update timing");
   chk_slot_update: assert property (slot_req.valid && !rx_req.valid && mh_ready |=> s_sl)
      else $error("slot update timing");
   chk_hdr_answer: assert property (mh_ready && mh_req.valid && !mh_req.we
      && !mh_req.data_acc |=> mh_rvalid)
      else $error("header read unanswered");
   chk_data_start: assert property (reg_wr && reg_addr == 8'h00 |=>
      data_start == ({3'h0, $past(reg_wdata[7:0])} + 11'h001) * 11'h004)
      else $error("data start wrong");
   chk_bad_flag: assert property (bad |=> parity_error_flag)
      else $error("parity flag missing");
   chk_good_nmv: assert property (ext_chk.valid && ext_chk.mgmt && ext_chk.mgmt_match
      && !bad |=> nmv_update)
      else $error("vector update missing");
   chk_halt_chan: assert property (bad && ext_chk.path == mrp_pkg::P_TBF_CPC |=>
      tx_halt == ($past(ext_chk.chan) ? 2'h2 : 2'h1))
      else $error("halt channel wrong");
   chk_txreq_block: assert property (bad && ext_chk.path == mrp_pkg::P_IBF_MEM
      |=> txreq_block && !nmv_update)
      else $error("request not blocked");
endmodule : mrp_chk
bind mrp_message_ram mrp_chk mrp_chk_i (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .mh_req(mh_req), .mh_ready(mh_ready),
   .mh_rvalid(mh_rvalid), .rx_req(rx_req), .slot_req(slot_req), .ext_chk(ext_chk),
   .txreq_block(txreq_block), .tx_halt(tx_halt), .nmv_update(nmv_update),
   .data_start(data_start), .parity_error_flag(parity_error_flag));

// file: verif/mrp_far_model.sv
`timescale 1ns/100ps
module mrp_far_model (
   // Clock
   input wire logic mclk,
   // Words read back from staging and transient RAMs
   output mrp_pkg::mrp_ext_chk_type ext_chk
);
   initial ext_chk = '0;
   // Bad forces the stored parity wrong
   task automatic send(input mrp_pkg::mrp_path_type p, input logic ch, bad, mg,
                       input logic [6:0] b, input logic [31:0] d);
      @(posedge mclk);
      ext_chk <= {1'b1, p, ch, mg, mg, b, (^d) ^ bad, d};
      @(posedge mclk);
      ext_chk.valid <= 1'b0;
      // Released word must not keep looking valid
      ext_chk.word <= ~ext_chk.word;
   endtask : send
endmodule : mrp_far_model

// file: verif/tb_mrp_message_ram.sv
`timescale 1ns/100ps
module tb_mrp_message_ram;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, mh_rdata, v;
   mrp_pkg::mrp_mh_req_type mh_req = '0;
   mrp_pkg::mrp_rx_req_type rx_req = '0;
   mrp_pkg::mrp_slot_req_type slot_req = '0;
   mrp_pkg::mrp_ext_chk_type ext_chk;
   logic mh_ready, mh_rvalid, txreq_block, buf_ignore, tx_abandon, nmv_update, pe;
   logic [6:0] ext_evt_buf, mem_evt_buf;
   logic [1:0] tx_halt;
   logic [10:0] data_start;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #10 mclk = ~mclk;
   mrp_message_ram mrp_message_ram_i (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mh_req(mh_req), .mh_ready(mh_ready), .mh_rdata(mh_rdata), .mh_rvalid(mh_rvalid),
      .rx_req(rx_req), .slot_req(slot_req), .ext_chk(ext_chk), .txreq_block(txreq_block),
      .ext_evt_buf(ext_evt_buf), .buf_ignore(buf_ignore), .tx_abandon(tx_abandon),
      .mem_evt_buf(mem_evt_buf), .tx_halt(tx_halt), .nmv_update(nmv_update),
      .data_start(data_start), .parity_error_flag(pe));
   mrp_far_model mrp_far_model_i (.mclk(mclk), .ext_chk(ext_chk));
   task automatic results;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         $display("mismatch at %0t got %h expected %h", $time, g, e);
         errors++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
   endtask : rd
   task automatic idle;
      int n;
      n = 0;
      @(negedge mclk);
      while (mh_ready !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
   endtask : idle
   // Pointer 0x040 sits in the data partition, length is three units
   task automatic mh(input logic we, da, input logic [6:0] b, input logic [10:0] ix,
                     input logic [31:0] d);
      idle();
      @(posedge mclk);
      mh_req <= {1'b1, we, da, mrp_pkg::P_IBF_MEM, b, ix, 11'h040, 7'h03, d};
      @(posedge mclk);
      mh_req.valid <= 1'b0;
      @(negedge mclk);
      v = (mh_rvalid === 1'b1) ? mh_rdata : 32'hdead_beef;
   endtask : mh
   task automatic t_regs;
      rd(8'h00);
      chk(v, 32'h0);
      rd(8'h0c);
      chk(v, 32'h4);
      rd(8'h10);
      chk(v, 32'h0);
      wr(8'h00, 32'h7);
      wr(8'h0c, 32'h1ff);
      rd(8'h0c);
      chk(v, 32'h20);
   endtask : t_regs
   task automatic t_rx;
      mh(1'b1, 1'b0, 7'h03, 11'h1, 32'h0012_0345);
      mh(1'b1, 1'b0, 7'h03, 11'h2, 32'h0000_0040);
      idle();
      @(posedge mclk);
      rx_req <= {1'b1, 7'h03, 6'h2b, 6'h15, 7'h33};
      @(posedge mclk);
      rx_req.valid <= 1'b0;
      mh(1'b0, 1'b0, 7'h03, 11'h1, 32'h0);
      chk(v, 32'h3312_0345);
      mh(1'b0, 1'b0, 7'h03, 11'h2, 32'h0);
      chk(v, 32'h2b15_0040);
   endtask : t_rx
   // First pass transmit buffer, second receive
   task automatic t_slot;
      for (int i = 0; i < 2; i++) begin
         mh(1'b1, 1'b0, 7'h05, 11'h0, i ? 32'h3b00_0005 : 32'h3f00_0005);
         mh(1'b0, 1'b0, 7'h05, 11'h0, 32'h0);
         chk(v, i ? 32'h3b00_0005 : 32'h3f00_0005);
         idle();
         @(posedge mclk);
         slot_req <= {1'b1, 7'h05, 32'hffff_ffff};
         @(posedge mclk);
         slot_req.valid <= 1'b0;
         mh(1'b0, 1'b0, 7'h05, 11'h3, 32'h0);
         chk(v, i ? mrp_pkg::RX_KEEP : mrp_pkg::TX_KEEP);
      end
      chk({23'h0, tx_abandon, buf_ignore, mem_evt_buf}, 32'h0);
   endtask : t_slot
   task automatic t_data;
      mh(1'b1, 1'b1, 7'h00, 11'h0, 32'hffff_ffff);
      mh(1'b1, 1'b1, 7'h00, 11'h1, 32'hffff_ffff);
      mh(1'b1, 1'b1, 7'h00, 11'h2, 32'h1234_5678);
      mh(1'b0, 1'b1, 7'h00, 11'h1, 32'h0);
      chk(v, 32'h0000_ffff);
      mh(1'b0, 1'b1, 7'h00, 11'h0, 32'h0);
      chk(v, 32'hffff_ffff);
      mh(1'b0, 1'b1, 7'h00, 11'h2, 32'h0);
      chk(v, 32'hdead_beef);
      rd(8'h08);
      chk(v, 32'h0);
   endtask : t_data
   task automatic t_ext;
      mrp_pkg::mrp_path_type pt [5];
      logic [5:0] ex [5];
      pt = '{mrp_pkg::P_IBF_MEM, mrp_pkg::P_IBF_HOST, mrp_pkg::P_OBF_HOST,
             mrp_pkg::P_TBF_CPC, mrp_pkg::P_TBF_MEM};
      ex = '{6'h21, 6'h01, 6'h02, 6'h10, 6'h28};
      for (int i = 0; i < 5; i++) begin
         mrp_far_model_i.send(pt[i], i == 3, 1'b1, 1'b1, 7'(64 + i), 32'h0f0f_0001);
         rd(8'h04);
         chk({26'h0, v[5:0]}, {26'h0, ex[i]});
         rd(8'h08);
         chk(v, 32'h1);
         wr(8'h04, 32'h3f);
         wr(8'h08, 32'h1);
      end
      rd(8'h04);
      chk(v, 32'h0000_4400);
      rd(8'h08);
      chk(v, 32'h0);
      chk({25'h0, ext_evt_buf}, 32'h40);
      mrp_far_model_i.send(mrp_pkg::P_TBF_MEM, 1'b0, 1'b0, 1'b1, 7'h01, 32'h3);
      @(negedge mclk);
      chk({31'h0, nmv_update}, 32'h1);
   endtask : t_ext
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end
   initial begin
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      t_regs();
      t_rx();
      t_slot();
      t_data();
      t_ext();
      results();
   end
endmodule : tb_mrp_message_ram
